//--- rtl/tpg_top.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tpg_top (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	// Pins
	input  wire logic [7:0]  pb_pin_i,
	output var  logic [7:0]  pb_pin_o,
	output var  logic [7:0]  pb_pin_oe,
	input  wire logic [6:0]  pc_pin_i,
	output var  logic [6:0]  pc_pin_o,
	output var  logic [6:0]  pc_pin_oe,
	input  wire logic [6:0]  pd_pin_i
);
	typedef struct packed {
		logic [7:0]  port_two_data_latch;
		logic [6:0]  port_three_data_latch;
		logic [7:0]  port_two_direction;
		logic [6:0]  port_three_direction;
		logic        wr_pend;
		logic [9:0]  wr_addr;
		logic [31:0] rdata;
	} tpg_st_t;
	tpg_st_t st_q;
	tpg_st_t st_d;

	logic [7:0] pb_lvl;
	logic [6:0] pc_lvl;
	logic [6:0] pd_lvl;
	logic [7:0] pb_view;
	logic [6:0] pc_view;
	logic       addr_ok;
	logic [9:0] a_addr;
	logic [31:0] rd_mux;

	// ==========================================================
	// Pin synchronisers
	tpg_sync #(.W(tpg_pkg::PB_W)) u_sync_pb (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.pin_i   (pb_pin_i),
		.level_o (pb_lvl)
	);
	tpg_sync #(.W(tpg_pkg::PC_W)) u_sync_pc (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.pin_i   (pc_pin_i),
		.level_o (pc_lvl)
	);
	tpg_sync #(.W(tpg_pkg::PD_W)) u_sync_pd (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.pin_i   (pd_pin_i),
		.level_o (pd_lvl)
	);

	// ==========================================================
	// Read view: per-bit latch or pin
	generate
		for (genvar i = 0; i < tpg_pkg::PB_W; i++)
		begin : g_pb
			assign pb_view[i] = st_q.port_two_direction[i] ?
				st_q.port_two_data_latch[i] : pb_lvl[i];
		end
		for (genvar j = 0; j < tpg_pkg::PC_W; j++)
		begin : g_pc
			assign pc_view[j] = st_q.port_three_direction[j] ?
				st_q.port_three_data_latch[j] : pc_lvl[j];
		end
	endgenerate

	// ==========================================================
	// Address phase decode
	assign a_addr  = haddr[9:0];
	assign addr_ok = hsel && hready && (htrans == tpg_pkg::HTRANS_NONSEQ ||
		htrans == tpg_pkg::HTRANS_SEQ);

	// Read data mux; unmapped reads as zero with OKAY
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (a_addr == tpg_pkg::ADDR_PB_DATA)
			rd_mux = {24'h00_0000, pb_view};
		else if (a_addr == tpg_pkg::ADDR_PC_DATA)
			rd_mux = {25'h0, pc_view};
		else if (a_addr == tpg_pkg::ADDR_PD_LVL)
			rd_mux = {25'h0, pd_lvl};
		else if (a_addr == tpg_pkg::ADDR_PB_DIR)
			rd_mux = {24'h00_0000, st_q.port_two_direction};
		else if (a_addr == tpg_pkg::ADDR_PC_DIR)
			rd_mux = {25'h0, st_q.port_three_direction};
	end

	// ==========================================================
	// Next state: write data phase, read capture
	always_comb
	begin
		st_d = st_q;
		st_d.wr_pend = addr_ok && hwrite;
		if (addr_ok)
			st_d.wr_addr = a_addr;
		if (addr_ok && !hwrite)
			st_d.rdata = rd_mux;
		// Writes land whatever the direction bits say
		if (st_q.wr_pend)
		begin
			if (st_q.wr_addr == tpg_pkg::ADDR_PB_DATA)
				st_d.port_two_data_latch = hwdata[7:0];
			else if (st_q.wr_addr == tpg_pkg::ADDR_PC_DATA)
				st_d.port_three_data_latch = hwdata[6:0];
			else if (st_q.wr_addr == tpg_pkg::ADDR_PB_DIR)
				st_d.port_two_direction = hwdata[7:0];
			else if (st_q.wr_addr == tpg_pkg::ADDR_PC_DIR)
				st_d.port_three_direction = hwdata[6:0];
		end
		// Input-only port has no writable state: writes dropped
		if (rst)
		begin
			// Latches keep contents across reset
			st_d.port_two_direction   = tpg_pkg::DIR_RST;
			st_d.port_three_direction = tpg_pkg::DIR_RST[6:0];
			st_d.wr_pend = 1'b0;
			st_d.wr_addr = 10'h000;
			st_d.rdata   = 32'h0000_0000;
		end
	end

	// Clock enable freezes everything, reset included
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
			st_q <= st_d;
	end

	// ==========================================================
	// Outputs: read data and pins from flops, hreadyout and hresp tied off
	always_comb
	begin
		hrdata    = st_q.rdata;
		hreadyout = 1'b1; // zero wait states
		hresp     = 1'b0;
		pb_pin_o  = st_q.port_two_data_latch;
		pb_pin_oe = st_q.port_two_direction;
		pc_pin_o  = st_q.port_three_data_latch;
		pc_pin_oe = st_q.port_three_direction;
	end
	// Software ordering of latch then direction is not enforced

	// ==========================================================
	// Assertions: reset behaviour
	a_dir_b_reset: assert property (@(posedge ref_clk)
		(rst && clk_en) |=> (pb_pin_oe == 8'h00))
		else $error("port two direction not cleared by reset");
	a_dir_c_reset: assert property (@(posedge ref_clk)
		(rst && clk_en) |=> (pc_pin_oe == 7'h00))
		else $error("port three direction not cleared by reset");
	a_latch_b_keep: assert property (@(posedge ref_clk)
		(rst && clk_en) |=> $stable(pb_pin_o))
		else $error("port two latch changed by reset");
	a_latch_c_keep: assert property (@(posedge ref_clk)
		(rst && clk_en) |=> $stable(pc_pin_o))
		else $error("port three latch changed by reset");
	a_rdata_reset: assert property (@(posedge ref_clk)
		(rst && clk_en) |=> (hrdata == 32'h0000_0000))
		else $error("read data not cleared by reset");

	// ==========================================================
	// Assertions: writes land, nothing else moves
	a_latch_b_write: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PB_DATA)
		|=> (pb_pin_o == $past(hwdata[7:0])))
		else $error("port two latch write lost");
	a_latch_c_write: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PC_DATA)
		|=> (pc_pin_o == $past(hwdata[6:0])))
		else $error("port three latch write lost");
	a_latch_b_hold: assert property (@(posedge ref_clk)
		disable iff (rst)
		!(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PB_DATA)
		|=> $stable(pb_pin_o))
		else $error("port two latch moved without a write");
	a_latch_c_hold: assert property (@(posedge ref_clk)
		disable iff (rst)
		!(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PC_DATA)
		|=> $stable(pc_pin_o))
		else $error("port three latch moved without a write");
	a_dir_b_write: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PB_DIR)
		|=> (pb_pin_oe == $past(hwdata[7:0])))
		else $error("port two direction write lost");
	a_dir_c_write: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PC_DIR)
		|=> (pc_pin_oe == $past(hwdata[6:0])))
		else $error("port three direction write lost");
	a_dir_b_hold: assert property (@(posedge ref_clk)
		disable iff (rst)
		!(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PB_DIR)
		|=> $stable(pb_pin_oe))
		else $error("port two direction moved without a write");
	a_dir_c_hold: assert property (@(posedge ref_clk)
		disable iff (rst)
		!(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PC_DIR)
		|=> $stable(pc_pin_oe))
		else $error("port three direction moved without a write");
	// Input-only port owns no state, so a write there must be dropped
	a_in_no_write: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && st_q.wr_pend && st_q.wr_addr == tpg_pkg::ADDR_PD_LVL)
		|=> ($stable(pb_pin_o) && $stable(pc_pin_o) &&
		$stable(pb_pin_oe) && $stable(pc_pin_oe)))
		else $error("write to input-only port changed state");

	// ==========================================================
	// Assertions: read data
	// Read data is captured at the address-phase edge, so the
	// expected value is the one sampled at that edge.
	a_read_b_mix: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && addr_ok && !hwrite && a_addr == tpg_pkg::ADDR_PB_DATA)
		|=> (hrdata[7:0] == (($past(pb_pin_o) & $past(pb_pin_oe)) |
		($past(pb_lvl) & ~$past(pb_pin_oe)))))
		else $error("port two read mix wrong");
	a_read_c_mix: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && addr_ok && !hwrite && a_addr == tpg_pkg::ADDR_PC_DATA)
		|=> (hrdata == {25'h0, ($past(pc_pin_o) & $past(pc_pin_oe)) |
		($past(pc_lvl) & ~$past(pc_pin_oe))}))
		else $error("port three read mix wrong");
	a_read_d_pin: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && addr_ok && !hwrite && a_addr == tpg_pkg::ADDR_PD_LVL)
		|=> (hrdata == {25'h0, $past(pd_lvl)}))
		else $error("input-only port read wrong");
	a_read_b_dir: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && addr_ok && !hwrite && a_addr == tpg_pkg::ADDR_PB_DIR)
		|=> (hrdata == {24'h0, $past(pb_pin_oe)}))
		else $error("port two direction read wrong");
	a_read_c_dir: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && addr_ok && !hwrite && a_addr == tpg_pkg::ADDR_PC_DIR)
		|=> (hrdata == {25'h0, $past(pc_pin_oe)}))
		else $error("port three direction read wrong");
	a_read_none: assert property (@(posedge ref_clk)
		disable iff (rst)
		(clk_en && addr_ok && !hwrite &&
		a_addr != tpg_pkg::ADDR_PB_DATA && a_addr != tpg_pkg::ADDR_PC_DATA &&
		a_addr != tpg_pkg::ADDR_PD_LVL && a_addr != tpg_pkg::ADDR_PB_DIR &&
		a_addr != tpg_pkg::ADDR_PC_DIR) |=> (hrdata == 32'h0000_0000))
		else $error("unmapped read not zero");
	// Data phase of a read must not be disturbed by idle cycles
	a_rdata_hold: assert property (@(posedge ref_clk)
		disable iff (rst)
		!(clk_en && addr_ok && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");

	// ==========================================================
	// Assertions: per-pin read path and buffer enables
	// A buffer may only turn on as the result of a direction write
	generate
		for (genvar k = 0; k < tpg_pkg::PB_W; k++)
		begin : g_chk_pb
			a_rd_b_out: assert property (@(posedge ref_clk)
				disable iff (rst)
				(clk_en && addr_ok && !hwrite && pb_pin_oe[k] &&
				a_addr == tpg_pkg::ADDR_PB_DATA)
				|=> (hrdata[k] == $past(pb_pin_o[k])))
				else $error("port two output pin read wrong");
			a_rd_b_in: assert property (@(posedge ref_clk)
				disable iff (rst)
				(clk_en && addr_ok && !hwrite && !pb_pin_oe[k] &&
				a_addr == tpg_pkg::ADDR_PB_DATA)
				|=> (hrdata[k] == $past(pb_lvl[k])))
				else $error("port two input pin read wrong");
			a_oe_b_rise: assert property (@(posedge ref_clk)
				disable iff (rst)
				$rose(pb_pin_oe[k]) |-> ($past(st_q.wr_pend) &&
				$past(st_q.wr_addr) == tpg_pkg::ADDR_PB_DIR))
				else $error("port two buffer on without a write");
		end
		for (genvar m = 0; m < tpg_pkg::PC_W; m++)
		begin : g_chk_pc
			a_rd_c_out: assert property (@(posedge ref_clk)
				disable iff (rst)
				(clk_en && addr_ok && !hwrite && pc_pin_oe[m] &&
				a_addr == tpg_pkg::ADDR_PC_DATA)
				|=> (hrdata[m] == $past(pc_pin_o[m])))
				else $error("port three output pin read wrong");
			a_rd_c_in: assert property (@(posedge ref_clk)
				disable iff (rst)
				(clk_en && addr_ok && !hwrite && !pc_pin_oe[m] &&
				a_addr == tpg_pkg::ADDR_PC_DATA)
				|=> (hrdata[m] == $past(pc_lvl[m])))
				else $error("port three input pin read wrong");
			a_oe_c_rise: assert property (@(posedge ref_clk)
				disable iff (rst)
				$rose(pc_pin_oe[m]) |-> ($past(st_q.wr_pend) &&
				$past(st_q.wr_addr) == tpg_pkg::ADDR_PC_DIR))
				else $error("port three buffer on without a write");
		end
		for (genvar n = 0; n < tpg_pkg::PD_W; n++)
		begin : g_chk_pd
			a_rd_d_bit: assert property (@(posedge ref_clk)
				disable iff (rst)
				(clk_en && addr_ok && !hwrite &&
				a_addr == tpg_pkg::ADDR_PD_LVL)
				|=> (hrdata[n] == $past(pd_lvl[n])))
				else $error("input-only pin read wrong");
		end
	endgenerate

	// ==========================================================
	// Assertions: bus response and clock enable
	a_bus_okay: assert property (@(posedge ref_clk)
		(hresp == 1'b0) && (hreadyout == 1'b1))
		else $error("bus response not OKAY with zero wait");
	// Low enable freezes every flop, reset and bus included
	a_freeze: assert property (@(posedge ref_clk)
		!clk_en |=> $stable(st_q))
		else $error("state changed while clock enable low");
endmodule : tpg_top
`default_nettype wire

//--- include/tpg_pkg.sv
`default_nettype none
package tpg_pkg;
	// ==========================================================
	// Register map (printed offsets are not word multiples, so
	// byte address is four times the index)
	localparam logic [7:0] IDX_PB_DATA = 8'h01;
	localparam logic [7:0] IDX_PC_DATA = 8'h02;
	localparam logic [7:0] IDX_PD_LVL  = 8'h03;
	localparam logic [7:0] IDX_PB_DIR  = 8'h05;
	localparam logic [7:0] IDX_PC_DIR  = 8'h06;
	localparam logic [9:0] ADDR_PB_DATA = {IDX_PB_DATA, 2'b00};
	localparam logic [9:0] ADDR_PC_DATA = {IDX_PC_DATA, 2'b00};
	localparam logic [9:0] ADDR_PD_LVL  = {IDX_PD_LVL, 2'b00};
	localparam logic [9:0] ADDR_PB_DIR  = {IDX_PB_DIR, 2'b00};
	localparam logic [9:0] ADDR_PC_DIR  = {IDX_PC_DIR, 2'b00};
	localparam int ADDR_W = 10;
	// ==========================================================
	// Port widths and reset values
	localparam int PB_W = 8;
	localparam int PC_W = 7;
	localparam int PD_W = 7;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] LATCH_INIT = 8'h00;
	// ==========================================================
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage : tpg_pkg
`default_nettype wire

//--- rtl/tpg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser with agreement filter
module tpg_sync #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] pin_i,
	output var  logic [W-1:0] level_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} tpg_sync_st_t;
	tpg_sync_st_t st_q;
	tpg_sync_st_t st_d;

	// Per-bit acceptance once stages two and three agree
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = pin_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < W; i++)
		begin
			if (st_q.s2[i] == st_q.s3[i])
				st_d.lvl[i] = st_q.s3[i];
		end
	end

	// Reset leaves levels alone; they take the pin value once stages two and three agree
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
			st_q <= st_d;
	end

	assign level_o = st_q.lvl;
endmodule : tpg_sync
`default_nettype wire

//--- test/tpg_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pads of the two bidirectional ports with an outside source
module tpg_pins (
	input  wire logic [7:0] pb_o,
	input  wire logic [7:0] pb_oe,
	input  wire logic [6:0] pc_o,
	input  wire logic [6:0] pc_oe,
	input  wire logic [7:0] pb_ext,
	input  wire logic [6:0] pc_ext,
	output var  logic [7:0] pb_lvl,
	output var  logic [6:0] pc_lvl
);
	// An enabled buffer overrides the outside source, else pad floats to it
	always_comb
	begin
		pb_lvl = (pb_oe & pb_o) | (~pb_oe & pb_ext);
		pc_lvl = (pc_oe & pc_o) | (~pc_oe & pc_ext);
	end
endmodule : tpg_pins
`default_nettype wire

//--- test/tpg_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_top_test;
	logic        ref_clk, rst, clk_en, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0]  pb_pin_i, pb_pin_o, pb_pin_oe, pb_ext;
	logic [6:0]  pc_pin_i, pc_pin_o, pc_pin_oe, pc_ext, pd_pin_i;
	int          error_cnt, check_count;
	// ==========================================================
	// Device and its pads
	tpg_top u_tpg_top (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pb_pin_i(pb_pin_i), .pb_pin_o(pb_pin_o), .pb_pin_oe(pb_pin_oe),
		.pc_pin_i(pc_pin_i), .pc_pin_o(pc_pin_o), .pc_pin_oe(pc_pin_oe),
		.pd_pin_i(pd_pin_i));
	tpg_pins u_tpg_pins (.pb_o(pb_pin_o), .pb_oe(pb_pin_oe),
		.pc_o(pc_pin_o), .pc_oe(pc_pin_oe), .pb_ext(pb_ext),
		.pc_ext(pc_ext), .pb_lvl(pb_pin_i), .pc_lvl(pc_pin_i));
	// ==========================================================
	// Shared tasks
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Bounded wait; a stuck bus ends the run rather than hanging
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1 && n < 50)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 50)
		begin
			error_cnt++;
			stop_test();
		end
	endtask : wait_rdy
	// One single AHB transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [7:0] wd);
		haddr <= {22'h0, a};
		htrans <= tpg_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rd = hrdata;
		chk("hresp", {7'h0, hresp}, 8'h00);
	endtask : bus
	task automatic do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
	endtask : do_reset
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		bus(1'b1, tpg_pkg::ADDR_PB_DATA, 8'h96);
		bus(1'b1, tpg_pkg::ADDR_PC_DATA, 8'h2d);
		bus(1'b1, tpg_pkg::ADDR_PB_DIR, 8'hff);
		bus(1'b1, tpg_pkg::ADDR_PC_DIR, 8'h7f);
		do_reset();
		chk("pb_oe", pb_pin_oe, 8'h00);
		chk("pc_oe", {1'b0, pc_pin_oe}, 8'h00);
		chk("pb_o", pb_pin_o, 8'h96);
		chk("pc_o", {1'b0, pc_pin_o}, 8'h2d);
		bus(1'b0, tpg_pkg::ADDR_PB_DIR, 8'h00);
		chk("pb_dir", rd[7:0], 8'h00);
		bus(1'b0, tpg_pkg::ADDR_PC_DIR, 8'h00);
		chk("pc_dir", rd[7:0], 8'h00);
	endtask : t_reset
	task automatic t_port_two();
		pb_ext <= 8'h3c;
		bus(1'b1, tpg_pkg::ADDR_PB_DATA, 8'ha5);
		repeat (6) @(posedge ref_clk);
		chk("pb_o", pb_pin_o, 8'ha5);
		bus(1'b0, tpg_pkg::ADDR_PB_DATA, 8'h00);
		chk("pb_rd_in", rd[7:0], 8'h3c);
		bus(1'b1, tpg_pkg::ADDR_PB_DIR, 8'hf0);
		repeat (6) @(posedge ref_clk);
		chk("pb_oe", pb_pin_oe, 8'hf0);
		bus(1'b0, tpg_pkg::ADDR_PB_DATA, 8'h00);
		chk("pb_rd_mix", rd[7:0], 8'hac);
		clk_en <= 1'b0;
		bus(1'b1, tpg_pkg::ADDR_PB_DATA, 8'h11);
		clk_en <= 1'b1;
		@(posedge ref_clk);
		chk("pb_o_frozen", pb_pin_o, 8'ha5);
	endtask : t_port_two
	task automatic t_port_three();
		pc_ext <= 7'h15;
		bus(1'b1, tpg_pkg::ADDR_PC_DATA, 8'hff);
		repeat (6) @(posedge ref_clk);
		chk("pc_o", {1'b0, pc_pin_o}, 8'h7f);
		bus(1'b0, tpg_pkg::ADDR_PC_DATA, 8'h00);
		chk("pc_rd_in", rd[7:0], 8'h15);
		bus(1'b1, tpg_pkg::ADDR_PC_DIR, 8'hff);
		@(posedge ref_clk);
		chk("pc_oe", {1'b0, pc_pin_oe}, 8'h7f);
		bus(1'b0, tpg_pkg::ADDR_PC_DIR, 8'h00);
		chk("pc_dir", rd[7:0], 8'h7f);
		bus(1'b0, tpg_pkg::ADDR_PC_DATA, 8'h00);
		chk("pc_rd_out", rd[7:0], 8'h7f);
	endtask : t_port_three
	task automatic t_input();
		pd_pin_i <= 7'h55;
		repeat (6) @(posedge ref_clk);
		bus(1'b1, tpg_pkg::ADDR_PD_LVL, 8'h00);
		bus(1'b0, tpg_pkg::ADDR_PD_LVL, 8'h00);
		chk("pd_rd", rd[7:0], 8'h55);
		pd_pin_i <= 7'h7f;
		repeat (6) @(posedge ref_clk);
		bus(1'b0, tpg_pkg::ADDR_PD_LVL, 8'h00);
		chk("pd_rd_b7", rd[7:0], 8'h7f);
		do_reset();
		bus(1'b0, tpg_pkg::ADDR_PD_LVL, 8'h00);
		chk("pd_rd_rst", rd[7:0], 8'h7f);
		bus(1'b0, 10'h3fc, 8'h00);
		chk("unmapped", rd[7:0], 8'h00);
	endtask : t_input
	// ==========================================================
	// Clock and main sequence
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial
	begin
		rst = 1'b1;
		clk_en = 1'b1;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		pb_ext = 8'h00;
		pc_ext = 7'h00;
		pd_pin_i = 7'h00;
		do_reset();
		t_reset();
		t_port_two();
		t_port_three();
		t_input();
		stop_test();
	end
endmodule : tpg_top_test
`default_nettype wire
